// ### src/tmc_cfg.svh
/*
  constants of the transceiver mode controller: command codes, pin indices,
  reset values and timing counts. assumes a 50 MHz controller clock.
*/
`ifndef TMC_CFG_SVH
`define TMC_CFG_SVH

// mode_select command codes
`define TMC_CMD_SLEEP        3'h1
`define TMC_CMD_STANDBY      3'h4
`define TMC_CMD_NORMAL       3'h7

// bit positions of the analog/bus inputs in the pin carrier
`define TMC_NPINS            8
`define TMC_PIN_BAT_OK       7
`define TMC_PIN_OVERTEMP     6
`define TMC_PIN_VCC_UV       5
`define TMC_PIN_IO_UV        4
`define TMC_PIN_BUS_ACT      3
`define TMC_PIN_WAKE         2
`define TMC_PIN_STD_WAKE     1
`define TMC_PIN_SEL_FRAME    0

// reset values of wake configuration and status
`define TMC_RST_CAN_WAKE     1'b1
`define TMC_RST_SEL_WAKE     1'b0
`define TMC_RST_PIN_FALL     1'b0
`define TMC_RST_PIN_RISE     1'b0
`define TMC_RST_FORCED       1'b0

// timing, in ns, and derived cycle counts (rounded up)
`define TMC_CLK_PERIOD_NS    20
`define TMC_UVD_QUAL_NS      10000
`define TMC_UVD_SLEEP_NS     40000
`define TMC_SILENCE_NS       60000
`define TMC_CNT_W            16
`define TMC_CYC(ns)          (((ns) + `TMC_CLK_PERIOD_NS - 1) / `TMC_CLK_PERIOD_NS)
`define TMC_UVD_QUAL_CYC     `TMC_CYC(`TMC_UVD_QUAL_NS)
`define TMC_UVD_SLEEP_CYC    `TMC_CYC(`TMC_UVD_SLEEP_NS)
`define TMC_SILENCE_CYC      `TMC_CYC(`TMC_SILENCE_NS)

`endif

// ### src/tmc_pkg.sv
/*
  types of the transceiver mode controller: operating modes, wake
  configuration and the carrier of asynchronous comparator/bus inputs.
  assumes tmc_cfg.svh for the pin bit order.
*/
package tmc_pkg;

  typedef enum logic [2:0] {
    TMC_OFF,
    TMC_STANDBY,
    TMC_NORMAL,
    TMC_SLEEP,
    TMC_OVERTEMP
  } tmc_mode_e;

  typedef struct packed {
    logic can_wake_enable;
    logic selective_wake_enable;
    logic wake_pin_falling_enable;
    logic wake_pin_rising_enable;
  } tmc_wake_cfg_s;

  // field order matches the TMC_PIN_* bit indices
  typedef struct packed {
    logic battery_supply_ok;
    logic overtemp;
    logic vcc_uv;
    logic io_supply_uv;
    logic bus_activity;
    logic wake_pin;
    logic std_wake_pattern;
    logic selective_frame;
  } tmc_pins_s;

endpackage

// ### src/tmc_qualifier.sv
/*
  two-flop synchroniser plus a persistence counter for one asynchronous
  level. output rises after the synced input has been high qual_cycles
  cycles in a row and falls at once. assumes a single clock domain.
*/
`timescale 1ns/10ps
`default_nettype none

`include "tmc_cfg.svh"

module tmc_qualifier #(
  parameter int QUAL_CYCLES = 1
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic reset_i,
  // level in and out
  input  wire logic async_i,
  output var  logic level_o
);

  localparam logic [`TMC_CNT_W-1:0] LAST = (`TMC_CNT_W)'(QUAL_CYCLES - 1);

  logic                  meta;
  logic                  sync;
  logic [`TMC_CNT_W-1:0] cnt;
  logic [`TMC_CNT_W-1:0] next_cnt;
  logic                  next_level;

  always_comb begin
    next_cnt   = '0;
    next_level = 1'b0;
    if (sync) begin
      next_cnt   = (cnt == LAST) ? cnt : cnt + 1'b1;
      next_level = (cnt == LAST);
    end
  end

  // meta feeds only sync
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      meta    <= 1'b0;
      sync    <= 1'b0;
      cnt     <= '0;
      level_o <= 1'b0;
    end else begin
      meta    <= async_i;
      sync    <= meta;
      cnt     <= next_cnt;
      level_o <= next_level;
    end
  end

endmodule // tmc_qualifier

`default_nettype wire

// ### src/tmc_mode_ctrl.sv
/*
  operating-mode controller of a CAN transceiver: off, standby, normal,
  sleep and overtemp, host mode commands, sleep entry checks, wake and
  interrupt exits, undervoltage forced sleep. assumes analog comparators
  and bus detectors give levels on pins_i, and host command strobes come
  from logic on mclk_i.
*/
`timescale 1ns/10ps
`default_nettype none

`include "tmc_cfg.svh"

module tmc_mode_ctrl
  import tmc_pkg::*;
(
  // clock and reset
  input  wire logic          mclk_i,
  input  wire logic          reset_i,
  // comparator and bus detector levels, asynchronous
  input  wire tmc_pins_s     pins_i,
  // host commands, mclk domain
  input  wire logic          mode_wr_i,
  input  wire logic [2:0]    mode_select_i,
  input  wire logic          cfg_wr_i,
  input  wire tmc_wake_cfg_s cfg_i,
  input  wire logic          partial_net_config_valid_i,
  input  wire logic          wake_clear_i,
  input  wire logic          irq_pending_i,
  input  wire logic          spi_fault_flag_i,
  // mode and status
  output var  tmc_mode_e     mode_o,
  output var  logic          forced_sleep_status_o,
  output var  logic          wake_pending_o,
  output var  tmc_wake_cfg_s cfg_o,
  // pins
  output var  logic          regulator_inhibit_o,
  output var  logic          regulator_inhibit_oe_o,
  output var  logic          bus_oe_o,
  output var  logic          bus_bias_o,
  output var  logic          can_active_o,
  output var  logic          rxd_o
);

  localparam logic [`TMC_CNT_W-1:0] SLEEP_LAST = (`TMC_CNT_W)'(`TMC_UVD_SLEEP_CYC - 1);
  localparam logic [`TMC_CNT_W-1:0] SIL_LAST   = (`TMC_CNT_W)'(`TMC_SILENCE_CYC - 1);

  function automatic int qual_count(input int idx);
    if (idx == `TMC_PIN_VCC_UV || idx == `TMC_PIN_IO_UV) begin
      return `TMC_UVD_QUAL_CYC;
    end
    return 1;
  endfunction

  // a command is taken in the active modes only
  function automatic logic cmd_mode(input tmc_mode_e m);
    return (m == TMC_STANDBY) || (m == TMC_NORMAL) || (m == TMC_SLEEP);
  endfunction

  // undervoltage timer runs only in normal and standby
  function automatic logic uv_mode(input tmc_mode_e m);
    return (m == TMC_NORMAL) || (m == TMC_STANDBY);
  endfunction

  logic [`TMC_NPINS-1:0] raw;
  logic [`TMC_NPINS-1:0] q;

  assign raw = pins_i;

  genvar gi;
  generate
    for (gi = 0; gi < `TMC_NPINS; gi++) begin : g_qual
      tmc_qualifier #(
        .QUAL_CYCLES (qual_count(gi))
      ) u_qual (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .async_i (raw[gi]),
        .level_o (q[gi])
      );
    end
  endgenerate

  tmc_mode_e             mode;
  tmc_mode_e             next_mode;
  tmc_wake_cfg_s         cfg;
  tmc_wake_cfg_s         next_cfg;
  logic                  fss;
  logic                  next_fss;
  logic                  wake_pend;
  logic                  next_wake_pend;
  logic [`TMC_CNT_W-1:0] uv_cnt;
  logic [`TMC_CNT_W-1:0] next_uv_cnt;
  logic [`TMC_CNT_W-1:0] sil_cnt;
  logic [`TMC_CNT_W-1:0] next_sil_cnt;
  logic                  bias;
  logic                  next_bias;
  logic [2:0]            prev;
  logic [2:0]            next_prev;
  logic                  bat_ok;
  logic                  hot;
  logic                  uv;
  logic                  io_ok;
  logic                  sleep_ok;
  logic                  uv_done;
  logic                  wake_event;
  logic                  bus_wake;
  logic                  pin_rise;
  logic                  pin_fall;
  logic                  forced;
  logic                  next_inh_oe;
  logic                  next_bus_oe;
  logic                  next_bus_bias;
  logic                  next_can_active;
  logic                  next_rxd;

  assign bat_ok = q[`TMC_PIN_BAT_OK];
  assign hot    = q[`TMC_PIN_OVERTEMP];
  assign uv     = q[`TMC_PIN_VCC_UV] | q[`TMC_PIN_IO_UV];
  assign io_ok  = ~q[`TMC_PIN_IO_UV];

  // wake detection
  always_comb begin
    next_prev = {q[`TMC_PIN_WAKE], q[`TMC_PIN_STD_WAKE], q[`TMC_PIN_SEL_FRAME]};
    pin_rise  = q[`TMC_PIN_WAKE] & ~prev[2];
    pin_fall  = ~q[`TMC_PIN_WAKE] & prev[2];
    if (cfg.selective_wake_enable && partial_net_config_valid_i) begin
      bus_wake = q[`TMC_PIN_SEL_FRAME] & ~prev[0];
    end else begin
      bus_wake = q[`TMC_PIN_STD_WAKE] & ~prev[1];
    end
    // overtemp and off detect nothing; a pending wake still stands
    wake_event = cmd_mode(mode) &
                 ((bus_wake & cfg.can_wake_enable) |
                  (pin_rise & cfg.wake_pin_rising_enable) |
                  (pin_fall & cfg.wake_pin_falling_enable));
  end

  // undervoltage delay and bus silence timer
  always_comb begin
    next_uv_cnt = '0;
    if (uv && uv_mode(mode)) begin
      next_uv_cnt = (uv_cnt == SLEEP_LAST) ? uv_cnt : uv_cnt + 1'b1;
    end
    uv_done = uv && uv_mode(mode) && (uv_cnt == SLEEP_LAST);
    next_sil_cnt = '0;
    next_bias    = 1'b1;
    if (!q[`TMC_PIN_BUS_ACT]) begin
      next_sil_cnt = (sil_cnt == SIL_LAST) ? sil_cnt : sil_cnt + 1'b1;
      next_bias    = bias & (sil_cnt != SIL_LAST);
    end
  end

  // mode sequencing
  always_comb begin
    next_mode = mode;
    next_fss  = fss;
    next_cfg  = cfg_wr_i ? cfg_i : cfg;
    forced    = 1'b0;
    sleep_ok  = ~wake_pend & (cfg.can_wake_enable | cfg.wake_pin_falling_enable |
                              cfg.wake_pin_rising_enable);
    unique case (mode)
      TMC_OFF: begin
        if (bat_ok) next_mode = TMC_STANDBY;
      end
      TMC_OVERTEMP: begin
        if (!hot) next_mode = TMC_STANDBY;
      end
      TMC_NORMAL, TMC_STANDBY: begin
        if (mode == TMC_NORMAL && hot) begin
          next_mode = TMC_OVERTEMP;
        end else if (mode_wr_i) begin
          case (mode_select_i)
            `TMC_CMD_NORMAL: begin
              if (mode == TMC_STANDBY) next_mode = TMC_NORMAL;
            end
            `TMC_CMD_STANDBY: begin
              if (mode == TMC_NORMAL) next_mode = TMC_STANDBY;
            end
            `TMC_CMD_SLEEP: begin
              if (sleep_ok) begin
                next_mode = TMC_SLEEP;
                next_fss  = 1'b0;
              end else begin
                next_mode = TMC_STANDBY;
              end
            end
            default: next_mode = mode;
          endcase
        end
        if (uv_done && !(mode == TMC_NORMAL && hot)) begin
          forced    = 1'b1;
          next_mode = TMC_SLEEP;
          next_fss  = 1'b1;
          next_cfg  = '{can_wake_enable: 1'b1, selective_wake_enable: 1'b0,
                        wake_pin_falling_enable: 1'b1, wake_pin_rising_enable: 1'b1};
        end
      end
      TMC_SLEEP: begin
        // spi fault alone does not wake
        if (wake_pend || irq_pending_i) begin
          next_mode = TMC_STANDBY;
        end else if (mode_wr_i && io_ok) begin
          case (mode_select_i)
            `TMC_CMD_NORMAL:  next_mode = TMC_NORMAL;
            `TMC_CMD_STANDBY: next_mode = TMC_STANDBY;
            default:          next_mode = mode;
          endcase
        end
      end
    endcase
    if (!bat_ok) next_mode = TMC_OFF;
    // a new event beats a host clear in the same cycle
    next_wake_pend = (wake_pend & ~wake_clear_i) | wake_event;
    if (forced) next_wake_pend = 1'b0;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mode      <= TMC_OFF;
      fss       <= `TMC_RST_FORCED;
      cfg       <= '{can_wake_enable: `TMC_RST_CAN_WAKE, selective_wake_enable: `TMC_RST_SEL_WAKE,
                     wake_pin_falling_enable: `TMC_RST_PIN_FALL, wake_pin_rising_enable: `TMC_RST_PIN_RISE};
      wake_pend <= 1'b0;
      uv_cnt    <= '0;
      sil_cnt   <= '0;
      bias      <= 1'b0;
      prev      <= '0;
    end else begin
      mode      <= next_mode;
      fss       <= next_fss;
      cfg       <= next_cfg;
      wake_pend <= next_wake_pend;
      uv_cnt    <= next_uv_cnt;
      sil_cnt   <= next_sil_cnt;
      bias      <= next_bias;
      prev      <= next_prev;
    end
  end

  // pin values from the next state, so pins move on the same edge as mode_o
  always_comb begin
    // high-impedance in sleep and off
    next_inh_oe     = (next_mode == TMC_STANDBY) || (next_mode == TMC_NORMAL) ||
                      (next_mode == TMC_OVERTEMP);
    next_bus_oe     = cmd_mode(next_mode);
    next_bus_bias   = cmd_mode(next_mode) & (next_bias | (next_mode == TMC_NORMAL));
    next_can_active = (next_mode == TMC_NORMAL);
    next_rxd        = ~(next_wake_pend | irq_pending_i | spi_fault_flag_i);
  end

  // registered outputs, all but regulator_inhibit_o (held at 1) derived from next values so they track the mode
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mode_o                 <= TMC_OFF;
      forced_sleep_status_o  <= `TMC_RST_FORCED;
      wake_pending_o         <= 1'b0;
      cfg_o                  <= '0;
      regulator_inhibit_o    <= 1'b0;
      regulator_inhibit_oe_o <= 1'b0;
      bus_oe_o               <= 1'b0;
      bus_bias_o             <= 1'b0;
      can_active_o           <= 1'b0;
      rxd_o                  <= 1'b1;
    end else begin
      mode_o                 <= next_mode;
      forced_sleep_status_o  <= next_fss;
      wake_pending_o         <= next_wake_pend;
      cfg_o                  <= next_cfg;
      regulator_inhibit_o    <= 1'b1;
      regulator_inhibit_oe_o <= next_inh_oe;
      bus_oe_o               <= next_bus_oe;
      bus_bias_o             <= next_bus_bias;
      can_active_o           <= next_can_active;
      rxd_o                  <= next_rxd;
    end
  end

endmodule // tmc_mode_ctrl

`default_nettype wire

// ### verification/tmc_mode_chk.sv
/*
  assertions on the ports of the mode controller.
  assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/10ps
`default_nettype none

module tmc_mode_chk
  import tmc_pkg::*;
(
  // clock and reset
  input wire logic          mclk_i,
  input wire logic          reset_i,
  // inputs
  input wire tmc_pins_s     pins_i,
  input wire logic          mode_wr_i,
  input wire logic [2:0]    mode_select_i,
  input wire logic          irq_pending_i,
  input wire logic          spi_fault_flag_i,
  // outputs
  input wire tmc_mode_e     mode_o,
  input wire logic          forced_sleep_status_o,
  input wire logic          wake_pending_o,
  input wire tmc_wake_cfg_s cfg_o,
  input wire logic          regulator_inhibit_oe_o,
  input wire logic          bus_oe_o,
  input wire logic          can_active_o,
  input wire logic          rxd_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // raw pins only, so supply or heat events lag; bench keeps them apart from commands
  logic quiet;
  logic src;
  assign quiet = pins_i.battery_supply_ok && !pins_i.overtemp && !pins_i.vcc_uv && !pins_i.io_supply_uv;
  assign src = cfg_o.can_wake_enable | cfg_o.wake_pin_falling_enable | cfg_o.wake_pin_rising_enable;

  a_cmd_normal: assert property (mode_wr_i && mode_select_i == 3'h7 && mode_o == TMC_STANDBY && quiet
    |=> mode_o == TMC_NORMAL) else $error("normal command not taken");
  a_cmd_standby: assert property (mode_wr_i && mode_select_i == 3'h4 && mode_o == TMC_NORMAL && quiet
    |=> mode_o == TMC_STANDBY) else $error("standby command not taken");
  a_sleep_entry: assert property (mode_wr_i && mode_select_i == 3'h1 && quiet && !wake_pending_o && src
    && mode_o inside {TMC_STANDBY, TMC_NORMAL} |=> mode_o == TMC_SLEEP && !forced_sleep_status_o)
    else $error("sleep command not taken");
  a_sleep_refused: assert property (mode_wr_i && mode_select_i == 3'h1 && mode_o == TMC_STANDBY && quiet
    && (wake_pending_o || !src) |=> mode_o == TMC_STANDBY) else $error("refused sleep left standby");
  a_other_code: assert property (mode_wr_i && !(mode_select_i inside {3'h1, 3'h4, 3'h7}) && quiet
    && mode_o inside {TMC_STANDBY, TMC_NORMAL} |=> $stable(mode_o)) else $error("ignored code moved mode");
  a_sleep_pins: assert property (mode_o == TMC_SLEEP
    |-> !regulator_inhibit_oe_o && bus_oe_o && !can_active_o) else $error("sleep pin state wrong");
  a_standby_pins: assert property (mode_o == TMC_STANDBY
    |-> regulator_inhibit_oe_o && !can_active_o) else $error("standby pin state wrong");
  a_off_pins: assert property (mode_o == TMC_OFF
    |-> !regulator_inhibit_oe_o && !bus_oe_o) else $error("off pins not released");
  a_irq_exit: assert property (mode_o == TMC_SLEEP && irq_pending_i && quiet
    |=> mode_o == TMC_STANDBY) else $error("interrupt did not end sleep");
  a_rxd_low: assert property ((spi_fault_flag_i || irq_pending_i) && mode_o != TMC_OFF && quiet
    |=> !rxd_o) else $error("rxd not low on event");
  a_ot_entry: assert property ((pins_i.overtemp && pins_i.battery_supply_ok) [*4] ##0 mode_o == TMC_NORMAL
    |=> mode_o == TMC_OVERTEMP) else $error("overtemp not entered");
  a_forced_cfg: assert property ($rose(forced_sleep_status_o)
    |-> mode_o == TMC_SLEEP && cfg_o == 4'hb && !wake_pending_o) else $error("forced sleep state wrong");
endmodule // tmc_mode_chk

bind tmc_mode_ctrl tmc_mode_chk i_tmc_mode_chk (.mclk_i, .reset_i, .pins_i, .mode_wr_i, .mode_select_i,
  .irq_pending_i, .spi_fault_flag_i, .mode_o, .forced_sleep_status_o, .wake_pending_o, .cfg_o,
  .regulator_inhibit_oe_o, .bus_oe_o, .can_active_o, .rxd_o);

`default_nettype wire

// ### verification/tmc_host_model.sv
/*
  host side of the mode controller: mode, wake configuration and clear writes.
  assumes mclk_i from the bench; one strobe per call.
*/
`timescale 1ns/10ps
`default_nettype none

module tmc_host_model
  import tmc_pkg::*;
(
  // clock
  input  wire logic         mclk_i,
  // command strobes
  output var logic          mode_wr_o,
  output var logic [2:0]    mode_select_o,
  output var logic          cfg_wr_o,
  output var tmc_wake_cfg_s cfg_o,
  output var logic          wake_clear_o
);
  initial begin
    {mode_wr_o, cfg_wr_o, wake_clear_o, mode_select_o, cfg_o} = 10'h0;
  end

  // kind 0 mode, 1 config, 2 clear; data held through the taking edge
  task automatic send(input logic [1:0] kind, input logic [3:0] val);
    @(posedge mclk_i);
    #1;
    mode_select_o = val[2:0];
    cfg_o = val;
    mode_wr_o = kind == 2'h0;
    cfg_wr_o = kind == 2'h1;
    wake_clear_o = kind == 2'h2;
    @(posedge mclk_i);
    #1;
    {mode_wr_o, cfg_wr_o, wake_clear_o} = 3'h0;
  endtask
endmodule // tmc_host_model

`default_nettype wire

// ### verification/test_transceiver_mode_controller.sv
/*
  bench of the mode controller: host model, pin stimulus, scenario tasks.
  assumes the package, the config header and the bound checker.
*/
`timescale 1ns/10ps
`default_nettype none

module test_transceiver_mode_controller;
  import tmc_pkg::*;
  logic               mclk_i, reset_i, pnc_ok, irq, spi_fault_flag;
  tmc_pins_s          pins;
  wire logic          mode_wr, cfg_wr, wclr;
  wire logic [2:0]    msel;
  wire tmc_wake_cfg_s hcfg;
  tmc_mode_e          mode_o;
  tmc_wake_cfg_s      cfg_o;
  logic               fss, wpend, regulator_inhibit_output, inh_oe, bus_oe, bias, act, rxd;
  int                 fails, samples_checked, n;

  tmc_host_model i_tmc_host_model (.mclk_i, .mode_wr_o(mode_wr), .mode_select_o(msel), .cfg_wr_o(cfg_wr),
    .cfg_o(hcfg), .wake_clear_o(wclr));
  tmc_mode_ctrl i_tmc_mode_ctrl (.mclk_i, .reset_i, .pins_i(pins), .mode_wr_i(mode_wr), .mode_select_i(msel),
    .cfg_wr_i(cfg_wr), .cfg_i(hcfg), .partial_net_config_valid_i(pnc_ok), .wake_clear_i(wclr),
    .irq_pending_i(irq), .spi_fault_flag_i(spi_fault_flag), .mode_o, .forced_sleep_status_o(fss),
    .wake_pending_o(wpend), .cfg_o, .regulator_inhibit_o(regulator_inhibit_output), .regulator_inhibit_oe_o(inh_oe),
    .bus_oe_o(bus_oe), .bus_bias_o(bias), .can_active_o(act), .rxd_o(rxd));

  initial begin
    mclk_i = 1'h0;
    forever #10 mclk_i = ~mclk_i;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask

  task automatic wait_mode(input tmc_mode_e m, input int lim, output int cnt);
    cnt = 0;
    while (mode_o !== m && cnt < lim) begin
      cyc(1);
      cnt++;
    end
    if (mode_o !== m) begin
      fails++;
      $display("Error mode wait expected %h seen %h", m, mode_o);
      end_of_test();
    end
  endtask

  task automatic cmd(input logic [2:0] c);
    i_tmc_host_model.send(2'h0, {1'h0, c});
  endtask

  task automatic cfg(input logic [3:0] v);
    i_tmc_host_model.send(2'h1, v);
  endtask

  task automatic t_reset();
    chk("mode", TMC_OFF, mode_o);
    reset_i = 1'h0;
    wait_mode(TMC_STANDBY, 10, n);
    chk("inh_oe", 4'h1, inh_oe);
    chk("inh", 4'h1, regulator_inhibit_output);
    chk("cfg", 4'h8, cfg_o);
    chk("rxd", 4'h1, rxd);
  endtask

  task automatic t_codes();
    for (int c = 0; c < 8; c++)
      if (!(c inside {1, 4, 7})) begin
        cmd(c[2:0]);
        chk("mode", TMC_STANDBY, mode_o);
      end
    cmd(3'h7);
    chk("mode", TMC_NORMAL, mode_o);
    chk("active", 4'h1, act);
    chk("bias", 4'h1, bias);
    cmd(3'h5);
    chk("mode", TMC_NORMAL, mode_o);
    cmd(3'h4);
    chk("mode", TMC_STANDBY, mode_o);
  endtask

  task automatic t_sleep();
    cfg(4'h0);
    cmd(3'h1);
    chk("mode", TMC_STANDBY, mode_o);
    cfg(4'h1);
    cmd(3'h1);
    chk("mode", TMC_SLEEP, mode_o);
    chk("inh_oe", 4'h0, inh_oe);
    chk("bus_oe", 4'h1, bus_oe);
    chk("forced", 4'h0, fss);
    spi_fault_flag = 1'h1;
    cyc(4);
    chk("mode", TMC_SLEEP, mode_o);
    chk("rxd", 4'h0, rxd);
    spi_fault_flag = 1'h0;
    irq = 1'h1;
    cyc(1);
    chk("mode", TMC_STANDBY, mode_o);
    irq = 1'h0;
    cmd(3'h1);
    cmd(3'h7);
    chk("mode", TMC_NORMAL, mode_o);
    cmd(3'h1);
    chk("mode", TMC_SLEEP, mode_o);
    cmd(3'h4);
    chk("mode", TMC_STANDBY, mode_o);
  endtask

  task automatic t_wake();
    cfg(4'h8);
    pins.std_wake_pattern = 1'h1;
    cyc(5);
    chk("pending", 4'h1, wpend);
    pins.std_wake_pattern = 1'h0;
    cmd(3'h1);
    chk("mode", TMC_STANDBY, mode_o);
    i_tmc_host_model.send(2'h2, 4'h0);
    chk("pending", 4'h0, wpend);
    cmd(3'h1);
    pins.std_wake_pattern = 1'h1;
    wait_mode(TMC_STANDBY, 8, n);
    chk("rxd", 4'h0, rxd);
    pins.std_wake_pattern = 1'h0;
    i_tmc_host_model.send(2'h2, 4'h0);
    cfg(4'hc);
    pnc_ok = 1'h1;
    cmd(3'h1);
    pins.std_wake_pattern = 1'h1;
    cyc(8);
    chk("mode", TMC_SLEEP, mode_o);
    pins.selective_frame = 1'h1;
    wait_mode(TMC_STANDBY, 8, n);
    {pins.std_wake_pattern, pins.selective_frame, pnc_ok} = 3'h0;
    i_tmc_host_model.send(2'h2, 4'h0);
    cfg(4'h8);
  endtask

  // wake pin edges: only the enabled direction counts
  task automatic t_pin();
    cfg(4'h1);
    pins.wake_pin = 1'h1;
    cyc(5);
    chk("pending", 4'h1, wpend);
    i_tmc_host_model.send(2'h2, 4'h0);
    pins.wake_pin = 1'h0;
    cyc(5);
    chk("pending", 4'h0, wpend);
    cfg(4'h2);
    cmd(3'h1);
    chk("mode", TMC_SLEEP, mode_o);
    pins.wake_pin = 1'h1;
    cyc(6);
    chk("mode", TMC_SLEEP, mode_o);
    pins.wake_pin = 1'h0;
    wait_mode(TMC_STANDBY, 8, n);
    chk("rxd", 4'h0, rxd);
    i_tmc_host_model.send(2'h2, 4'h0);
    cfg(4'h8);
  endtask

  task automatic t_heat_bias();
    cmd(3'h7);
    pins.overtemp = 1'h1;
    wait_mode(TMC_OVERTEMP, 6, n);
    chk("bus_oe", 4'h0, bus_oe);
    pins.overtemp = 1'h0;
    wait_mode(TMC_STANDBY, 6, n);
    // bus activity toggles every 80 ns, a 160 ns link period
    repeat (8) begin
      cyc(4);
      pins.bus_activity = ~pins.bus_activity;
    end
    cyc(4);
    chk("bias", 4'h1, bias);
    n = 0;
    while (bias !== 1'h0 && n < 3100) begin
      cyc(1);
      n++;
    end
    chk("silence", 4'h1, n > 2980 && n < 3010);
    if (bias !== 1'h0) end_of_test();
  endtask

  task automatic t_uv_off();
    pins.std_wake_pattern = 1'h1;
    cyc(5);
    pins.vcc_uv = 1'h1;
    wait_mode(TMC_SLEEP, 2600, n);
    chk("uv delay", 4'h1, n >= 2500);
    chk("forced", 4'h1, fss);
    chk("cfg", 4'hb, cfg_o);
    chk("pending", 4'h0, wpend);
    {pins.vcc_uv, pins.std_wake_pattern} = 2'h0;
    cyc(4);
    cmd(3'h4);
    chk("mode", TMC_STANDBY, mode_o);
    cfg(4'h8);
    chk("cfg", 4'h8, cfg_o);
    cmd(3'h1);
    chk("forced", 4'h0, fss);
    // io supply low: host commands cannot wake sleep
    pins.io_supply_uv = 1'h1;
    cyc(510);
    cmd(3'h4);
    chk("mode", TMC_SLEEP, mode_o);
    pins.io_supply_uv = 1'h0;
    cyc(4);
    cmd(3'h4);
    chk("mode", TMC_STANDBY, mode_o);
    pins.battery_supply_ok = 1'h0;
    wait_mode(TMC_OFF, 6, n);
    chk("inh_oe", 4'h0, inh_oe);
    chk("bus_oe", 4'h0, bus_oe);
  endtask

  initial begin
    {fails, samples_checked, n} = '0;
    {reset_i, pnc_ok, irq, spi_fault_flag} = 4'h8;
    pins = '0;
    pins.battery_supply_ok = 1'h1;
    repeat (8) @(posedge mclk_i);
    #1;
    t_reset();
    t_codes();
    t_sleep();
    t_wake();
    t_pin();
    t_heat_bias();
    t_uv_off();
    end_of_test();
  end
endmodule // test_transceiver_mode_controller

`default_nettype wire
